/* common/sbk_pkg.sv */
// Shared constants for the safe brake output control block
package sbk_pkg;

    // ========================================================================
    // Clock and timing
    // ========================================================================
    localparam int CLK_PERIOD_NS    = 100;
    localparam int MS_NS            = 1000000;
    localparam int MS_CYCLES        = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROC_CYCLE_NS    = 2000000;
    localparam int PROC_CYCLES      = (PROC_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W            = 17;
    localparam logic [16:0] DLY_MAX_MS  = 17'h1d4c0;
    localparam logic [16:0] DLY_DFLT_MS = 17'h00014;

    // ========================================================================
    // Bus
    // ========================================================================
    localparam int WB_AW = 8;
    localparam int WB_DW = 32;
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_TON      = 8'h04;
    localparam logic [7:0] OFS_TOFF     = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // ========================================================================
    // Control register fields
    // ========================================================================
    localparam int CTRL_LINK_LSB = 0;
    localparam int CTRL_SRC_LSB  = 2;
    localparam int CTRL_TYPE_LSB = 4;
    localparam int CTRL_AXIS_BIT = 8;
    localparam int CTRL_LOCK_BIT = 9;

    // Drive link codes
    localparam logic [1:0] LINK_NONE = 2'h0;
    localparam logic [1:0] LINK_BRK1 = 2'h2;
    localparam logic [1:0] LINK_BRK2 = 2'h3;
    // Feedback source codes
    localparam logic [1:0] FBK_OFF  = 2'h0;
    localparam logic [1:0] FBK_FSOE = 2'h1;
    localparam logic [1:0] FBK_DRV1 = 2'h2;
    localparam logic [1:0] FBK_DRV2 = 2'h3;
    // Feedback contact type codes
    localparam logic [1:0] TYPE_NO  = 2'h1;
    localparam logic [1:0] TYPE_NC  = 2'h2;
    // Axis codes
    localparam logic AXIS_A1 = 1'b0;
    localparam logic AXIS_A2 = 1'b1;

    // Reset values
    localparam logic [1:0] LINK_RST = LINK_NONE;
    localparam logic [1:0] SRC_RST  = FBK_OFF;
    localparam logic [1:0] TYPE_RST = TYPE_NC;
    localparam logic       AXIS_RST = AXIS_A1;

    // ========================================================================
    // Status and interrupt fields
    // ========================================================================
    localparam int ST_BRAKE  = 0;
    localparam int ST_FBK    = 1;
    localparam int ST_EXPECT = 2;
    localparam int ST_BUSY   = 3;
    localparam int ST_TQOFF  = 4;
    localparam int ST_MRUN   = 5;
    localparam int ST_FERR   = 6;
    localparam int ST_ACTIVE = 7;
    localparam int IRQ_W     = 3;
    localparam int EV_FERR   = 0;
    localparam int EV_TQOFF  = 1;
    localparam int EV_CHG    = 2;

    // Instance limits
    localparam int MAX_INST_PER_AXIS = 2;
    localparam int MAX_INST_PER_TYPE = 2;

endpackage

/* design/sbk_fbk_timer.sv */
// Feedback settle timer expiring on processing cycle boundaries
`timescale 1ns/10ps
module sbk_fbk_timer #(
    parameter int DW = 17
) (
    input  wire logic          sys_clk_i,
    input  wire logic          srst_i,
    input  wire logic          start_i,
    input  wire logic [DW-1:0] delay_ms_i,
    input  wire logic          ms_tick_i,
    input  wire logic          proc_tick_i,
    output logic               busy_o,
    output logic               expired_o
);
    typedef struct packed {
        logic          busy;
        logic          expired;
        logic [DW-1:0] elapsed;
    } sbk_tmr_type;

    sbk_tmr_type r;
    sbk_tmr_type n;

    always_comb
    begin
        n = r;
        if (start_i)
        begin
            n.busy    = 1'b1;
            n.expired = 1'b0;
            n.elapsed = '0;
        end
        else if (r.busy)
        begin
            if (ms_tick_i && (r.elapsed != {DW{1'b1}}))
            begin
                n.elapsed = r.elapsed + DW'(1);
            end
            // Expiry only at a cycle boundary: rounds delay up
            if (proc_tick_i && (r.elapsed >= delay_ms_i))
            begin
                n.busy    = 1'b0;
                n.expired = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign busy_o    = r.busy;
    assign expired_o = r.expired;

endmodule // sbk_fbk_timer

/* design/sbk_brake_ctrl.sv */
// Safe brake output control for one drive axis with feedback check
`timescale 1ns/10ps
module sbk_brake_ctrl #(
    parameter int MS_CYCLES     = sbk_pkg::MS_CYCLES,
    parameter int PROC_CYCLES   = sbk_pkg::PROC_CYCLES,
    parameter int INST_ON_AXIS  = 1,
    parameter int INST_OF_TYPE  = 1
) (
    input  wire logic                         sys_clk_i,
    input  wire logic                         srst_i,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [sbk_pkg::WB_AW-1:0]    wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [sbk_pkg::WB_DW-1:0]    wb_dat_i,
    output logic      [sbk_pkg::WB_DW-1:0]    wb_dat_o,
    output logic                              wb_ack_o,
    input  wire logic [1:0]                   torque_off_state_i,
    input  wire logic [1:0]                   monitored_run_state_i,
    input  wire logic [1:0]                   drive_brake_req_i,
    input  wire logic                         fsoe_fbk_i,
    input  wire logic [1:0]                   drive_fbk_i,
    output logic                              brake_drive_output_o,
    output logic      [1:0]                   stop_one_function_o,
    output logic                              irq_o
);
    import sbk_pkg::*;

    localparam int MS_W   = $clog2(MS_CYCLES + 1);
    localparam int PROC_W = $clog2(PROC_CYCLES + 1);

    // ========================================================================
    // Instance limits
    // ========================================================================
    if ((INST_ON_AXIS > MAX_INST_PER_AXIS) || (INST_OF_TYPE > MAX_INST_PER_TYPE))
    begin : g_inst_limit
        $error("Too many brake control instances");
    end

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic              ack;
        logic [31:0]       rdat;
        logic [1:0]        link;
        logic [1:0]        src;
        logic [1:0]        ftype;
        logic              axis;
        logic              locked;
        logic [DLY_W-1:0]  ton;
        logic [DLY_W-1:0]  toff;
        logic [IRQ_W-1:0]  istat;
        logic [IRQ_W-1:0]  imask;
        logic              brake;
        logic              tq_off_d;
        logic              ferr;
        logic [1:0]        stop_req;
        logic [MS_W-1:0]   ms_cnt;
        logic [PROC_W-1:0] proc_cnt;
    } sbk_state_type;

    sbk_state_type r;
    sbk_state_type n;

    logic             req;
    logic             wr;
    logic             tq_off;
    logic             mrun;
    logic             cmd;
    logic             fbk;
    logic             mon_en;
    logic             expect_now;
    logic             expect_new;
    logic             start;
    logic             tmr_busy;
    logic             tmr_expired;
    logic             ms_tick;
    logic             proc_tick;
    logic             ferr_now;
    logic [DLY_W-1:0] dly_sel;
    logic [IRQ_W-1:0] ev;
    logic [31:0]      status;
    logic [31:0]      ctrl_word;
    logic [31:0]      wmerge;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (dat & m);
    endfunction

    function automatic logic [DLY_W-1:0] clamp(input logic [31:0] v);
        return (v > 32'(DLY_MAX_MS)) ? DLY_MAX_MS : v[DLY_W-1:0];
    endfunction

    // ========================================================================
    // Brake command
    // ========================================================================
    always_comb
    begin
        tq_off = torque_off_state_i[r.axis];
        mrun   = monitored_run_state_i[r.axis];
        // Torque-off forces engage; covers stop-one error shutdown
        if (tq_off)
        begin
            cmd = 1'b0;
        end
        else
        begin
            case (r.link)
                LINK_BRK1: cmd = drive_brake_req_i[0];
                LINK_BRK2: cmd = drive_brake_req_i[1];
                default:   cmd = 1'b1;
            endcase
        end
    end

    // ========================================================================
    // Feedback check
    // ========================================================================
    always_comb
    begin
        case (r.src)
            FBK_FSOE: fbk = fsoe_fbk_i;
            FBK_DRV1: fbk = drive_fbk_i[0];
            FBK_DRV2: fbk = drive_fbk_i[1];
            default:  fbk = 1'b0;
        endcase
        mon_en = (r.src != FBK_OFF);
        // Expected level per contact type
        expect_now = (r.ftype == TYPE_NO) ? r.brake : ~r.brake;
        expect_new = (r.ftype == TYPE_NO) ? cmd : ~cmd;
        // Rising expectation uses on-delay, falling the off-delay
        dly_sel = expect_new ? r.ton : r.toff;
        // Restart the timer on each command change or control register write
        start = (cmd != r.brake) || (wr && (wb_adr_i == OFS_CTRL));
        ferr_now = mon_en && !tmr_busy && !start && (fbk != expect_now);
    end

    assign ms_tick   = (r.ms_cnt == MS_W'(MS_CYCLES - 1));
    assign proc_tick = (r.proc_cnt == PROC_W'(PROC_CYCLES - 1));

    sbk_fbk_timer #(
        .DW          (DLY_W)
    ) u_timer (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .start_i     (start),
        .delay_ms_i  (dly_sel),
        .ms_tick_i   (ms_tick),
        .proc_tick_i (proc_tick),
        .busy_o      (tmr_busy),
        .expired_o   (tmr_expired)
    );

    // ========================================================================
    // Register access
    // ========================================================================
    assign req = wb_cyc_i && wb_stb_i;
    assign wr  = req && wb_we_i && r.ack;

    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[CTRL_LINK_LSB +: 2] = r.link;
        ctrl_word[CTRL_SRC_LSB +: 2]  = r.src;
        ctrl_word[CTRL_TYPE_LSB +: 2] = r.ftype;
        ctrl_word[CTRL_AXIS_BIT]      = r.axis;
        ctrl_word[CTRL_LOCK_BIT]      = r.locked;
        status = '0;
        status[ST_BRAKE]  = r.brake;
        status[ST_FBK]    = fbk;
        status[ST_EXPECT] = expect_now;
        status[ST_BUSY]   = tmr_busy;
        status[ST_TQOFF]  = tq_off;
        status[ST_MRUN]   = mrun;
        status[ST_FERR]   = r.ferr;
        status[ST_ACTIVE] = tq_off; // Active with torque-off, no own input
    end

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb
    begin
        n = r;
        wmerge = '0;
        n.ms_cnt   = (ms_tick || start) ? '0 : r.ms_cnt + MS_W'(1);
        n.proc_cnt = proc_tick ? '0 : r.proc_cnt + PROC_W'(1);
        n.brake    = cmd;
        n.tq_off_d = tq_off;
        n.ferr     = ferr_now;
        n.stop_req = 2'b00;
        n.stop_req[r.axis] = ferr_now && !r.ferr;
        ev = '0;
        ev[EV_FERR]  = ferr_now && !r.ferr;
        ev[EV_TQOFF] = tq_off && !r.tq_off_d;
        ev[EV_CHG]   = cmd != r.brake;
        n.ack = req && !r.ack;
        if (req && !r.ack)
        begin
            case (wb_adr_i)
                OFS_CTRL:     n.rdat = ctrl_word;
                OFS_TON:      n.rdat = 32'(r.ton);
                OFS_TOFF:     n.rdat = 32'(r.toff);
                OFS_STATUS:   n.rdat = status;
                OFS_IRQ_STAT: n.rdat = 32'(r.istat);
                OFS_IRQ_MASK: n.rdat = 32'(r.imask);
                default:      n.rdat = '0;
            endcase
        end
        if (wr)
        begin
            case (wb_adr_i)
                OFS_CTRL:
                begin
                    wmerge  = merge(ctrl_word, wb_dat_i, wb_sel_i);
                    n.link  = wmerge[CTRL_LINK_LSB +: 2];
                    n.src   = wmerge[CTRL_SRC_LSB +: 2];
                    n.ftype = wmerge[CTRL_TYPE_LSB +: 2];
                    // Axis binding frozen after the first control write that enables byte lane 1
                    if (!r.locked && wb_sel_i[1])
                    begin
                        n.axis   = wmerge[CTRL_AXIS_BIT];
                        n.locked = 1'b1;
                    end
                end
                OFS_TON:
                begin
                    n.ton = clamp(merge(32'(r.ton), wb_dat_i, wb_sel_i));
                end
                OFS_TOFF:
                begin
                    n.toff = clamp(merge(32'(r.toff), wb_dat_i, wb_sel_i));
                end
                OFS_IRQ_STAT:
                begin
                    if (wb_sel_i[0])
                    begin
                        n.istat = r.istat & ~wb_dat_i[IRQ_W-1:0];
                    end
                end
                OFS_IRQ_MASK:
                begin
                    wmerge  = merge(32'(r.imask), wb_dat_i, wb_sel_i);
                    n.imask = wmerge[IRQ_W-1:0];
                end
                default: ;
            endcase
        end
        // Hardware set wins over a same-cycle clear
        n.istat = n.istat | ev;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            r       <= '0;
            r.link  <= LINK_RST;
            r.src   <= SRC_RST;
            r.ftype <= TYPE_RST;
            r.axis  <= AXIS_RST;
            r.ton   <= DLY_DFLT_MS;
            r.toff  <= DLY_DFLT_MS;
        end
        else
        begin
            r <= n;
        end
    end

    assign wb_dat_o             = r.rdat;
    assign wb_ack_o             = r.ack;
    assign brake_drive_output_o = r.brake;
    assign stop_one_function_o  = r.stop_req;
    assign irq_o                = |(r.istat & r.imask);

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    property p_tqoff_low;
        tq_off |=> !brake_drive_output_o;
    endproperty
    a_tqoff_low: assert property (p_tqoff_low)
        else $error("Brake output high during torque-off");

    property p_nolink_high;
        (!tq_off && (r.link != LINK_BRK1) && (r.link != LINK_BRK2)) |=> brake_drive_output_o;
    endproperty
    a_nolink_high: assert property (p_nolink_high)
        else $error("Brake not released while running without link");

    property p_link1_follow;
        (!tq_off && (r.link == LINK_BRK1))
            |=> (brake_drive_output_o == $past(drive_brake_req_i[0]));
    endproperty
    a_link1_follow: assert property (p_link1_follow)
        else $error("Brake output does not follow drive request 1");

    property p_link2_follow;
        (!tq_off && (r.link == LINK_BRK2))
            |=> (brake_drive_output_o == $past(drive_brake_req_i[1]));
    endproperty
    a_link2_follow: assert property (p_link2_follow)
        else $error("Brake output does not follow drive request 2");

    property p_err_stop;
        $rose(r.ferr) |-> stop_one_function_o[r.axis] && r.istat[EV_FERR];
    endproperty
    a_err_stop: assert property (p_err_stop)
        else $error("Feedback error did not trigger stop-one on bound axis");

    property p_mismatch_err;
        (mon_en && tmr_expired && !start && (fbk != expect_now)) |=> r.ferr;
    endproperty
    a_mismatch_err: assert property (p_mismatch_err)
        else $error("Expected feedback level mismatch not flagged");

    property p_start_quiet;
        start |=> !r.ferr && tmr_busy;
    endproperty
    a_start_quiet: assert property (p_start_quiet)
        else $error("Feedback error raised right after command change");

    property p_expire_on_tick;
        $rose(tmr_expired) |-> $past(proc_tick);
    endproperty
    a_expire_on_tick: assert property (p_expire_on_tick)
        else $error("Timer expired off a processing cycle boundary");

    property p_axis_locked;
        r.locked |=> $stable(r.axis) [*2];
    endproperty
    a_axis_locked: assert property (p_axis_locked)
        else $error("Axis binding changed after lock");

    c_link1: cover property (!tq_off && r.link == LINK_BRK1 ##1 $changed(brake_drive_output_o));
    c_ferr: cover property ($rose(r.ferr));
    c_expire: cover property ($rose(tmr_expired));
    c_tqoff: cover property ($rose(tq_off) ##1 !brake_drive_output_o);

endmodule // sbk_brake_ctrl

/* verif/sbk_brake_model.sv */
// Braking device with feedback contact, lagging the brake output
`timescale 1ns/10ps
module sbk_brake_model (
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    input  wire logic       brake_i,
    input  wire logic       nc_i,
    input  wire logic       stuck_i,
    input  wire logic [7:0] lag_i,
    output logic            fbk_o
);
    logic       lvl_r;
    logic [7:0] cnt_r;
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || stuck_i || brake_i == lvl_r)
            cnt_r <= 8'h00;
        else
            cnt_r <= cnt_r + 8'h01;
        if (srst_i)
            lvl_r <= 1'b0;
        else if (!stuck_i && brake_i != lvl_r && cnt_r >= lag_i)
            lvl_r <= brake_i;
    end
    // Contact polarity
    assign fbk_o = lvl_r ^ nc_i;
endmodule // sbk_brake_model

/* verif/testbench.sv */
// Self-checking bench for the safe brake output control
`timescale 1ns/10ps
module testbench;
    import sbk_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic        cyc = 1'b0, we = 1'b0, nc = 1'b0, stuck = 1'b0;
    logic        ack, brk, irq, fb;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic [1:0]  tq = 2'h3, req = 2'h0, fsel = 2'h0, stop;
    int          n_mismatch = 0, check_count = 0, n_stop0 = 0, n_stop1 = 0, base;

    always #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i)
    begin
        if (stop[0] === 1'b1)
            n_stop0 <= n_stop0 + 1;
        if (stop[1] === 1'b1)
            n_stop1 <= n_stop1 + 1;
    end

    sbk_brake_ctrl #(.MS_CYCLES(4), .PROC_CYCLES(6)) i_dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .torque_off_state_i(tq), .monitored_run_state_i(~tq),
        .drive_brake_req_i(req), .fsoe_fbk_i(fsel == 2'h1 ? fb : ~fb),
        .drive_fbk_i({fsel == 2'h3 ? fb : ~fb, fsel == 2'h2 ? fb : ~fb}),
        .brake_drive_output_o(brk), .stop_one_function_o(stop), .irq_o(irq));
    sbk_brake_model i_brake (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .brake_i(brk),
        .nc_i(nc), .stuck_i(stuck), .lag_i(8'h28), .fbk_o(fb));

    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic print_verdict();
        if (n_mismatch == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge sys_clk_i);
        cyc <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        if (ack !== 1'b1)
        begin
            chk(1'b0, 1'b1, "bus timeout");
            print_verdict();
        end
    endtask
    task automatic drv(input logic [1:0] t, input logic [1:0] r);
        @(posedge sys_clk_i);
        tq  <= t;
        req <= r;
        repeat (2) @(posedge sys_clk_i);
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_regs();
        wb(1'b0, OFS_CTRL, 32'h0, 4'hf);
        chk(q, 32'h20, "ctrl reset");
        wb(1'b0, OFS_TON, 32'h0, 4'hf);
        chk(q, {15'h0, DLY_DFLT_MS}, "ton reset");
        wb(1'b0, OFS_TOFF, 32'h0, 4'hf);
        chk(q, {15'h0, DLY_DFLT_MS}, "toff reset");
        wb(1'b1, OFS_TON, 32'h0001ffff, 4'hf);
        wb(1'b0, OFS_TON, 32'h0, 4'hf);
        chk(q, {15'h0, DLY_MAX_MS}, "ton clamp");
        wb(1'b1, OFS_TON, {15'h0, DLY_DFLT_MS}, 4'hf);
        wb(1'b1, 8'h1c, 32'hffffffff, 4'hf);
        wb(1'b0, 8'h1c, 32'h0, 4'hf);
        chk(q, 32'h0, "unmapped");
    endtask
    task automatic t_path();
        logic [1:0] lk[3] = '{LINK_NONE, LINK_BRK1, LINK_BRK2};
        foreach (lk[i])
        begin
            wb(1'b1, OFS_CTRL, {30'h0, lk[i]}, 4'h1);
            for (int r = 0; r < 4; r++)
            begin
                drv(2'h2, r[1:0]);
                chk(brk, lk[i] == LINK_BRK1 ? r[0] : lk[i] == LINK_BRK2 ? r[1] : 1'b1,
                    "run output");
                drv(2'h3, r[1:0]);
                chk(brk, 1'b0, "torque-off output");
            end
        end
    endtask
    task automatic t_fbk(input logic [1:0] src, input logic [1:0] typ);
        @(posedge sys_clk_i);
        fsel <= src;
        nc   <= (typ == TYPE_NC);
        drv(2'h2, 2'h1);
        repeat (60) @(posedge sys_clk_i);
        wb(1'b1, OFS_CTRL, {26'h0, typ, src, LINK_BRK1}, 4'h1);
        base = n_stop0;
        drv(2'h2, 2'h0);
        repeat (150) @(posedge sys_clk_i);
        drv(2'h2, 2'h1);
        repeat (150) @(posedge sys_clk_i);
        chk(n_stop0 - base, 0, "good feedback");
        stuck <= 1'b1;
        drv(2'h2, 2'h0);
        repeat (70) @(posedge sys_clk_i);
        chk(n_stop0 - base, 0, "early error");
        repeat (130) @(posedge sys_clk_i);
        chk(n_stop0 - base, src != FBK_OFF, "stop-one pulse");
        chk(n_stop1, 0, "stop-one on other axis");
        chk(irq, src != FBK_OFF, "irq raised");
        drv(2'h3, 2'h1);
        chk(brk, 1'b0, "stop-one engages");
        stuck <= 1'b0;
        drv(2'h2, 2'h0);
        repeat (150) @(posedge sys_clk_i);
        wb(1'b1, OFS_IRQ_STAT, 32'h1, 4'h1);
        repeat (2) @(posedge sys_clk_i);
        chk(irq, 1'b0, "irq cleared");
    endtask
    task automatic t_axis();
        wb(1'b0, OFS_IRQ_STAT, 32'h0, 4'hf);
        chk(q[EV_TQOFF], 1'b1, "torque-off event");
        wb(1'b0, OFS_IRQ_MASK, 32'h0, 4'hf);
        chk(q, 32'h1, "irq mask");
        wb(1'b1, OFS_CTRL, 32'h100, 4'h3);
        drv(2'h1, 2'h0);
        chk(brk, 1'b1, "axis 2 running");
        wb(1'b0, OFS_STATUS, 32'h0, 4'hf);
        chk(q, 32'h29, "status running");
        drv(2'h2, 2'h1);
        chk(brk, 1'b0, "axis 2 torque-off");
        wb(1'b0, OFS_STATUS, 32'h0, 4'hf);
        chk(q, 32'h9c, "status torque-off");
        wb(1'b1, OFS_CTRL, 32'h0, 4'h3);
        wb(1'b0, OFS_CTRL, 32'h0, 4'hf);
        chk(q[9:8], 2'h3, "axis locked");
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        t_regs();
        t_path();
        wb(1'b1, OFS_IRQ_MASK, 32'h1, 4'h1);
        t_fbk(FBK_FSOE, TYPE_NO);
        t_fbk(FBK_DRV1, TYPE_NC);
        t_fbk(FBK_DRV2, TYPE_NO);
        t_fbk(FBK_OFF, TYPE_NC);
        t_axis();
        print_verdict();
    end
endmodule // testbench
